// ==== design/sud_uart_data_port.sv ====
// module: uart data port, serial word exchange with transmitter, receiver, queue and interrupt
`default_nettype none
module sud_uart_data_port
  import sud_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       sclk,
  input  wire logic       csN,
  input  wire logic       mosi,
  output logic            miso,
  output logic            misoOe,
  input  wire logic       oscillatorInput,
  input  wire logic       rxd,
  output logic            txd,
  input  wire logic       ctsN,
  output logic            rtsN,
  output logic            irqN,
  input  wire logic [3:0] baudSelectField,
  input  wire logic       parityEnable,
  input  wire logic       sevenBitWords,
  input  wire logic       twoStopBits,
  input  wire logic       dataAvailableMask,
  input  wire logic       txEmptyMask,
  input  wire logic       framingMask
);

  typedef struct packed {
    // word exchange
    logic              sclkQ;
    logic              csNQ;
    logic [4:0]        riseCnt;
    logic [WORD_W-1:0] hostWord;
    logic [WORD_W-1:0] outWord;
    logic              isDataCmd;
    // control and flags
    logic              testMode;
    logic              rtsAsserted;
    logic [RX_W-1:0]   txBuf;
    logic              txBufFull;
    logic              txEmptyEvt;
    logic              framingFlag;
    // transmitter
    sud_line_e         txState;
    logic [3:0]        txSub;
    logic [2:0]        txBit;
    logic [RX_W-1:0]   txShift;
    logic              txLine;
    // receiver
    sud_line_e         rxState;
    logic [3:0]        rxSub;
    logic [2:0]        rxBit;
    logic [7:0]        rxShift;
    logic              rxParity;
    logic [RX_W-1:0]   hold;
    logic              holdValid;
  } sud_port_s;

  sud_port_s st_ff;
  sud_port_s nxt_st;

  logic            tick16;
  logic            clk16;
  logic            fifoInReady;
  logic            fifoOutValid;
  logic            fifoPop;
  logic [RX_W-1:0] fifoOutData;

  logic            sclkRise;
  logic            sclkFall;
  logic            selectStart;
  logic            wordDone;
  logic [2:0]      lastBit;
  logic [7:0]      rxDataOut;

  sud_baud i_sud_baud (
    .sys_clk         (sys_clk),
    .rst             (rst),
    .oscillatorInput (oscillatorInput),
    .baudSelectField (baudSelectField),
    .tick16          (tick16),
    .clk16           (clk16)
  );

  // received words wait here until the host reads them out
  sud_fifo #(
    .WIDTH (RX_W),
    .DEPTH (FIFO_DEPTH)
  ) i_sud_fifo (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .inValid  (st_ff.holdValid),
    .inReady  (fifoInReady),
    .inData   (st_ff.hold),
    .outValid (fifoOutValid),
    .outReady (fifoPop),
    .outData  (fifoOutData)
  );

  assign sclkRise    = sclk && !st_ff.sclkQ && !csN;
  assign sclkFall    = !sclk && st_ff.sclkQ && !csN;
  assign selectStart = !csN && st_ff.csNQ;
  assign wordDone    = sclkRise && (st_ff.riseCnt == CNT_WORD_DONE - 1'b1);
  assign lastBit     = sevenBitWords ? LAST_BIT7 : LAST_BIT8;
  assign fifoPop     = sclkFall && (st_ff.riseCnt == CNT_WORD_DONE) && st_ff.isDataCmd;
  assign rxDataOut   = sevenBitWords ? {1'b0, fifoOutData[6:0]} : fifoOutData[7:0];

  // pins
  assign miso   = st_ff.outWord[WORD_W-1];
  assign misoOe = !csN;
  assign txd    = (st_ff.testMode && !csN) ? 1'b0 : st_ff.txLine;
  assign rtsN   = (st_ff.testMode && !csN) ? clk16 : !st_ff.rtsAsserted;
  // level interrupt: data and framing sources stay until their cause is gone; tx-empty stays until a read or write data word
  assign irqN   = !((dataAvailableMask && fifoOutValid)
                  || (txEmptyMask && st_ff.txEmptyEvt)
                  || (framingMask && st_ff.framingFlag));

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.sclkQ = sclk;
    nxt_st.csNQ  = csN;

    // ---------------- word exchange ----------------
    if (csN) begin
      nxt_st.riseCnt = '0;
    end
    if (selectStart) begin
      // reply word is frozen as the select falls
      nxt_st.riseCnt = '0;
      nxt_st.outWord = {fifoOutValid, !st_ff.txBufFull, ZERO_GAP, st_ff.framingFlag,
                        !ctsN, fifoOutValid ? {fifoOutData[RX_W-1], rxDataOut} : {RX_W{1'b0}}};
    end
    if (sclkRise) begin
      nxt_st.hostWord = {st_ff.hostWord[WORD_W-2:0], mosi};
      nxt_st.riseCnt  = st_ff.riseCnt + 1'b1;
      if (st_ff.riseCnt == CNT_CMD_KNOWN - 1'b1) begin
        nxt_st.isDataCmd = (mosi == 1'b0); // 00 or 10, bit 14 clear
        if ({st_ff.hostWord[0], mosi} == CMD_READ_CONFIG) begin
          // configuration layout is not served here; trailing bits read zero
          nxt_st.outWord[WORD_W-2:0] = '0;
        end
      end
    end
    if (sclkFall && st_ff.riseCnt != '0) begin
      nxt_st.outWord = {st_ff.outWord[WORD_W-2:0], 1'b0};
    end

    // ---------------- transmit buffer and tx-empty source ----------------
    if (st_ff.txBufFull && st_ff.txState == LN_IDLE) begin
      nxt_st.txBufFull  = 1'b0;
      nxt_st.txEmptyEvt = 1'b1;
    end else if (wordDone && st_ff.isDataCmd) begin
      nxt_st.txEmptyEvt = 1'b0;
    end

    if (wordDone) begin
      case (st_ff.hostWord[WORD_W-2:WORD_W-3])
        CMD_WRITE_DATA: begin
          nxt_st.rtsAsserted = st_ff.hostWord[BIT_RTS-1];
          if (!st_ff.hostWord[BIT_SUPPRESS-1] && !st_ff.txBufFull) begin
            // a word arriving while the buffer is full is dropped; poll bit 14 first
            nxt_st.txBuf     = {st_ff.hostWord[BIT_PARITY-1:0], mosi};
            nxt_st.txBufFull = 1'b1;
          end
        end
        CMD_READ_CONFIG: begin
          nxt_st.testMode = (mosi == 1'b1);
        end
        default: begin
        end
      endcase
    end

    // ---------------- transmitter ----------------
    case (st_ff.txState)
      LN_IDLE: begin
        nxt_st.txLine = 1'b1;
        if (st_ff.txBufFull) begin
          nxt_st.txShift = st_ff.txBuf;
          nxt_st.txState = LN_START;
          nxt_st.txSub   = '0;
          nxt_st.txBit   = '0;
          nxt_st.txLine  = 1'b0;
        end
      end
      LN_START: begin
        if (tick16) begin
          nxt_st.txSub = st_ff.txSub + 1'b1;
          if (st_ff.txSub == SUB_LAST) begin
            nxt_st.txState = LN_DATA;
            nxt_st.txLine  = st_ff.txShift[0];
          end
        end
      end
      LN_DATA: begin
        if (tick16) begin
          nxt_st.txSub = st_ff.txSub + 1'b1;
          if (st_ff.txSub == SUB_LAST) begin
            nxt_st.txBit = st_ff.txBit + 1'b1;
            // the top data bit is never sent in seven-bit mode
            if (st_ff.txBit == lastBit) begin
              if (parityEnable) begin
                nxt_st.txState = LN_PARITY;
                nxt_st.txLine  = st_ff.txShift[RX_W-1];
              end else begin
                nxt_st.txState = LN_STOP;
                nxt_st.txLine  = 1'b1;
              end
            end else begin
              nxt_st.txLine = st_ff.txShift[st_ff.txBit + 1'b1];
            end
          end
        end
      end
      LN_PARITY: begin
        if (tick16) begin
          nxt_st.txSub = st_ff.txSub + 1'b1;
          if (st_ff.txSub == SUB_LAST) begin
            nxt_st.txState = LN_STOP;
            nxt_st.txLine  = 1'b1;
          end
        end
      end
      LN_STOP: begin
        if (tick16) begin
          nxt_st.txSub = st_ff.txSub + 1'b1;
          if (st_ff.txSub == SUB_LAST) begin
            nxt_st.txState = twoStopBits ? LN_STOP2 : LN_IDLE;
          end
        end
      end
      LN_STOP2: begin
        if (tick16) begin
          nxt_st.txSub = st_ff.txSub + 1'b1;
          if (st_ff.txSub == SUB_LAST) begin
            nxt_st.txState = LN_IDLE;
          end
        end
      end
      default: begin
        nxt_st.txState = LN_IDLE;
      end
    endcase

    // ---------------- receiver ----------------
    if (st_ff.holdValid && fifoInReady) begin
      nxt_st.holdValid = 1'b0;
    end
    case (st_ff.rxState)
      LN_IDLE: begin
        if (tick16 && !rxd) begin
          nxt_st.rxState = LN_START;
          nxt_st.rxSub   = '0;
        end
      end
      LN_START: begin
        if (tick16) begin
          nxt_st.rxSub = st_ff.rxSub + 1'b1;
          if (st_ff.rxSub == SUB_MID - 1'b1) begin
            // a start bit that is gone by mid-bit was a glitch
            nxt_st.rxSub   = '0;
            nxt_st.rxBit   = '0;
            nxt_st.rxState = rxd ? LN_IDLE : LN_DATA;
          end
        end
      end
      LN_DATA: begin
        if (tick16) begin
          nxt_st.rxSub = st_ff.rxSub + 1'b1;
          if (st_ff.rxSub == SUB_LAST) begin
            nxt_st.rxShift = {rxd, st_ff.rxShift[7:1]};
            nxt_st.rxBit   = st_ff.rxBit + 1'b1;
            if (st_ff.rxBit == lastBit) begin
              nxt_st.rxParity = 1'b0;
              nxt_st.rxState  = parityEnable ? LN_PARITY : LN_STOP;
            end
          end
        end
      end
      LN_PARITY: begin
        if (tick16) begin
          nxt_st.rxSub = st_ff.rxSub + 1'b1;
          if (st_ff.rxSub == SUB_LAST) begin
            nxt_st.rxParity = rxd;
            nxt_st.rxState  = LN_STOP;
          end
        end
      end
      LN_STOP: begin
        if (tick16) begin
          nxt_st.rxSub = st_ff.rxSub + 1'b1;
          if (st_ff.rxSub == SUB_LAST) begin
            nxt_st.rxState     = rxd ? LN_IDLE : LN_STOP2;
            nxt_st.framingFlag = !rxd;
            // a full queue drops the new word rather than stall the line
            if (rxd && !st_ff.holdValid) begin
              nxt_st.holdValid = 1'b1;
              nxt_st.hold      = {st_ff.rxParity,
                                  sevenBitWords ? {1'b0, st_ff.rxShift[7:1]} : st_ff.rxShift};
            end
          end
        end
      end
      LN_STOP2: begin
        // after a broken frame the line must go high again before a new start is hunted
        if (rxd) begin
          nxt_st.rxState = LN_IDLE;
        end
      end
      default: begin
        nxt_st.rxState = LN_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_ff          <= '0;
      st_ff.csNQ     <= 1'b1;
      st_ff.txLine   <= 1'b1;
      st_ff.txState  <= LN_IDLE;
      st_ff.rxState  <= LN_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : sud_uart_data_port
`default_nettype wire

// ==== design/sud_pkg.sv ====
// package: command codes, word layout, timing constants and enums of the serial uart data port
`default_nettype none
package sud_pkg;

  localparam int unsigned WORD_W     = 16;
  localparam int unsigned RX_W       = 9;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned DIV_W      = 9;

  // command field, word bits 15:14
  localparam logic [1:0] CMD_READ_DATA   = 2'h0;
  localparam logic [1:0] CMD_READ_CONFIG = 2'h1;
  localparam logic [1:0] CMD_WRITE_DATA  = 2'h2;

  // host word fields
  localparam int unsigned BIT_SUPPRESS = 10;
  localparam int unsigned BIT_RTS      = 9;
  localparam int unsigned BIT_PARITY   = 8;
  localparam int unsigned BIT_TEST     = 0;

  localparam logic [4:0] CNT_CMD_KNOWN = 5'h02;
  localparam logic [4:0] CNT_WORD_DONE = 5'h10;
  localparam logic [2:0] ZERO_GAP      = 3'h0;

  // sub-bit timing at 16x baud
  localparam logic [3:0] SUB_MID  = 4'h7;
  localparam logic [3:0] SUB_LAST = 4'hF;
  localparam logic [2:0] LAST_BIT8 = 3'h7;
  localparam logic [2:0] LAST_BIT7 = 3'h6;

  localparam logic [3:0] BAUD_SEL_RESET = 4'h0;
  localparam logic [DIV_W-1:0] DIV_BASE_LOW  = 9'h001;
  localparam logic [DIV_W-1:0] DIV_BASE_HIGH = 9'h003;

  typedef enum logic [2:0] {
    LN_IDLE   = 3'h0,
    LN_START  = 3'h1,
    LN_DATA   = 3'h3,
    LN_PARITY = 3'h2,
    LN_STOP   = 3'h6,
    LN_STOP2  = 3'h7
  } sud_line_e;

  // code 0xxx -> 1 << n, code 1xxx -> 3 << n
  function automatic logic [DIV_W-1:0] sud_divisor(input logic [3:0] sel);
    sud_divisor = (sel[3] ? DIV_BASE_HIGH : DIV_BASE_LOW) << sel[2:0];
  endfunction : sud_divisor

endpackage : sud_pkg
`default_nettype wire

// ==== design/sud_fifo.sv ====
// module: parameterised valid/ready fifo holding received words
`default_nettype none
module sud_fifo
  import sud_pkg::*;
#(
  parameter int unsigned WIDTH = RX_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0]   count;
  } sud_fifo_s;

  sud_fifo_s st_ff;
  sud_fifo_s nxt_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign inReady  = (st_ff.count != (AW+1)'(DEPTH));
  assign outValid = (st_ff.count != '0);
  assign outData  = mem[st_ff.rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.wrPtr = st_ff.wrPtr + 1'b1;
    end
    if (pop) begin
      nxt_st.rdPtr = st_ff.rdPtr + 1'b1;
    end
    nxt_st.count = st_ff.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[st_ff.wrPtr] <= inData;
    end
  end
endmodule : sud_fifo
`default_nettype wire

// ==== design/sud_baud.sv ====
// module: baud generator, divides the oscillator input into a 16x baud tick and level
`default_nettype none
module sud_baud
  import sud_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       oscillatorInput,
  input  wire logic [3:0] baudSelectField,
  output logic            tick16,
  output logic            clk16
);
  typedef struct packed {
    logic             oscQ;
    logic [DIV_W-1:0] cnt;
    logic             tick;
    logic             level;
  } sud_baud_s;

  sud_baud_s        st_ff;
  sud_baud_s        nxt_st;
  logic [DIV_W-1:0] baudDivisor;
  logic             oscRise;

  assign baudDivisor = sud_divisor(baudSelectField);
  assign oscRise     = oscillatorInput && !st_ff.oscQ;
  assign tick16      = st_ff.tick;
  assign clk16       = st_ff.level;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.oscQ = oscillatorInput;
    nxt_st.tick = 1'b0;
    if (oscRise) begin
      // one 16x tick per divisor oscillator periods
      if (st_ff.cnt >= baudDivisor - 1'b1) begin
        nxt_st.cnt  = '0;
        nxt_st.tick = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + 1'b1;
      end
    end
    // divide by one follows the oscillator itself; otherwise high while the count is below half the divisor, rounded down
    if (baudDivisor == DIV_BASE_LOW) begin
      nxt_st.level = oscillatorInput;
    end else begin
      nxt_st.level = (nxt_st.cnt < (baudDivisor >> 1));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : sud_baud
`default_nettype wire

// ==== sim/sud_host_model.sv ====
// partner: host master running 16-bit mode-0 word exchanges
`default_nettype none
module sud_host_model (
  input  wire logic        sys_clk,
  input  wire logic        start,
  input  wire logic        holdSelect,
  input  wire logic [15:0] txWord,
  output logic             busy,
  output logic      [15:0] rxWord,
  output logic             sclk,
  output logic             csN,
  output logic             mosi,
  input  wire logic        miso
);
  timeunit 1ns;
  timeprecision 1ps;
  // edges are spaced four system cycles apart, four times the one-cycle minimum the port accepts
  initial begin
    busy = 1'b0;
    sclk = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
    rxWord = 16'h0000;
    forever begin
      @(negedge sys_clk);
      csN = !holdSelect;
      if (start) begin
        busy = 1'b1;
        csN = 1'b0;
        repeat (4) @(negedge sys_clk);
        for (int i = 15; i >= 0; i--) begin
          mosi = txWord[i];
          repeat (4) @(negedge sys_clk);
          sclk = 1'b1;
          rxWord[i] = miso;
          repeat (4) @(negedge sys_clk);
          sclk = 1'b0;
        end
        repeat (8) @(negedge sys_clk);
        csN = 1'b1;
        mosi = ~mosi;
        repeat (3) @(negedge sys_clk);
        busy = 1'b0;
      end
    end
  end
endmodule : sud_host_model
`default_nettype wire

// ==== sim/sud_uart_data_port_chk.sv ====
// checker: port-level properties of the uart data port
`default_nettype none
module sud_uart_data_port_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic miso,
  input wire logic misoOe,
  input wire logic txd,
  input wire logic rtsN,
  input wire logic irqN,
  input wire logic dataAvailableMask,
  input wire logic txEmptyMask,
  input wire logic framingMask
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sclkQ;
  logic       csNQ;
  logic [4:0] riseCnt;
  logic [2:0] sinceEdge;
  always_ff @(posedge sys_clk) begin
    sclkQ <= sclk;
    csNQ <= csN;
    if (rst || csN) riseCnt <= 5'h00;
    else if (sclk && !sclkQ) riseCnt <= riseCnt + 5'h01;
    if (rst || (!sclk && sclkQ) || (csN != csNQ)) sinceEdge <= 3'h0;
    else if (sinceEdge != 3'h7) sinceEdge <= sinceEdge + 3'h1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_word_done;
    !csN && riseCnt == 5'h10;
  endsequence
  sequence s_start_bit;
    !txd [*8];
  endsequence
  chk_oe_follows_select: assert property (misoOe == !csN) else $error("miso enable off select");
  chk_reset_idle_lines: assert property ($fell(rst) |-> txd && rtsN && irqN && !miso)
    else $error("lines not idle after reset");
  chk_irq_needs_mask: assert property (!irqN |-> dataAvailableMask || txEmptyMask || framingMask)
    else $error("interrupt without mask");
  chk_miso_after_edge: assert property ($changed(miso) |-> sinceEdge <= 3'h4)
    else $error("miso moved away from clock edge");
  chk_rts_select_low: assert property ($changed(rtsN) |-> !csN || !$past(csN))
    else $error("rts moved while deselected");
  chk_start_bit_len: assert property ($fell(txd) && csN && $past(csN) |-> s_start_bit)
    else $error("start bit too short");
  chk_data_irq_clear: assert property ($rose(irqN) && dataAvailableMask && !txEmptyMask && !framingMask
    && $stable(dataAvailableMask) |-> s_word_done) else $error("data interrupt dropped outside a word");
  chk_tx_irq_clear: assert property ($rose(irqN) && txEmptyMask && !dataAvailableMask && !framingMask
    && $stable(txEmptyMask) |-> s_word_done) else $error("empty interrupt dropped outside a word");
endmodule : sud_uart_data_port_chk
bind sud_uart_data_port sud_uart_data_port_chk i_sud_uart_data_port_chk (.sys_clk(sys_clk), .rst(rst),
  .sclk(sclk), .csN(csN), .miso(miso), .misoOe(misoOe), .txd(txd), .rtsN(rtsN), .irqN(irqN),
  .dataAvailableMask(dataAvailableMask), .txEmptyMask(txEmptyMask), .framingMask(framingMask));
`default_nettype wire

// ==== sim/sud_uart_data_port_tb.sv ====
// testbench: directed scenarios for the uart data port
`default_nettype none
module sud_uart_data_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, rst, sclk, csN, mosi, miso, misoOe, oscillatorInput, rxd, txd, ctsN, rtsN, irqN;
  logic        parityEnable, sevenBitWords, twoStopBits, dataAvailableMask, txEmptyMask, framingMask;
  logic        start, busy, holdSelect;
  logic [3:0]  baudSelectField;
  logic [15:0] txWord, rxWord, r;
  logic [8:0]  v;
  int          nMismatch, checksDone;

  sud_uart_data_port i_sud_uart_data_port (.sys_clk(sys_clk), .rst(rst), .sclk(sclk), .csN(csN), .mosi(mosi),
    .miso(miso), .misoOe(misoOe), .oscillatorInput(oscillatorInput), .rxd(rxd), .txd(txd), .ctsN(ctsN),
    .rtsN(rtsN), .irqN(irqN), .baudSelectField(baudSelectField), .parityEnable(parityEnable),
    .sevenBitWords(sevenBitWords), .twoStopBits(twoStopBits), .dataAvailableMask(dataAvailableMask),
    .txEmptyMask(txEmptyMask), .framingMask(framingMask));
  sud_host_model i_sud_host_model (.sys_clk(sys_clk), .start(start), .holdSelect(holdSelect), .txWord(txWord),
    .busy(busy), .rxWord(rxWord), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // oscillator at a quarter of the system clock; one serial bit is 64 cycles at divisor 1
  initial begin
    oscillatorInput = 1'b0;
    forever begin
      repeat (2) @(negedge sys_clk);
      oscillatorInput = ~oscillatorInput;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nMismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic xfer(input logic [15:0] w, output logic [15:0] rd);
    @(negedge sys_clk);
    txWord = w;
    start = 1'b1;
    while (busy !== 1'b1) @(negedge sys_clk);
    start = 1'b0;
    while (busy !== 1'b0) @(negedge sys_clk);
    rd = rxWord;
  endtask : xfer

  task automatic send(input logic [8:0] b, input int n, input logic stopBit);
    rxd = 1'b0;
    repeat (64) @(negedge sys_clk);
    for (int i = 0; i < n; i++) begin
      rxd = b[i];
      repeat (64) @(negedge sys_clk);
    end
    rxd = stopBit;
    repeat (64) @(negedge sys_clk);
    rxd = 1'b1;
    repeat (64) @(negedge sys_clk);
  endtask : send

  // samples the transmit line mid-bit from the first data bit after the start bit on, lsb first
  task automatic grab(input int n, output logic [8:0] b);
    b = 9'h000;
    while (txd !== 1'b0) @(negedge sys_clk);
    repeat (32) @(negedge sys_clk);
    for (int i = 0; i < n; i++) begin
      repeat (64) @(negedge sys_clk);
      b[i] = txd;
    end
  endtask : grab

  task automatic rts_rise(output int t);
    t = 0;
    while (rtsN !== 1'b0) begin
      @(negedge sys_clk);
      t++;
    end
    while (rtsN !== 1'b1) begin
      @(negedge sys_clk);
      t++;
    end
  endtask : rts_rise

  task automatic t_idle;
    xfer(16'h0000, r);
    check(r, 16'h4000);
    check({15'h0000, irqN}, 16'h0001);
    $display("test idle done");
  endtask : t_idle

  task automatic t_write;
    ctsN = 1'b0;
    fork
      xfer(16'h8241, r);
      grab(9, v);
    join
    check(r, 16'h4200);
    check({15'h0000, rtsN}, 16'h0000);
    check({7'h00, v}, 16'h0141);
    txEmptyMask = 1'b1;
    @(negedge sys_clk);
    check({15'h0000, irqN}, 16'h0000);
    xfer(16'h0000, r);
    check({15'h0000, irqN}, 16'h0001);
    txEmptyMask = 1'b0;
    $display("test write done");
  endtask : t_write

  task automatic t_suppress;
    int lows;
    lows = 0;
    xfer(16'h8400, r);
    check({15'h0000, rtsN}, 16'h0001);
    repeat (200) begin
      @(negedge sys_clk);
      if (txd !== 1'b1) lows++;
    end
    check(16'(lows), 16'h0000);
    $display("test suppress done");
  endtask : t_suppress

  task automatic t_rx;
    parityEnable = 1'b1;
    dataAvailableMask = 1'b1;
    send(9'h1A5, 9, 1'b1);
    check({15'h0000, irqN}, 16'h0000);
    send(9'h03C, 9, 1'b1);
    xfer(16'h8400, r);
    check(r, 16'hC3A5);
    check({15'h0000, irqN}, 16'h0000);
    xfer(16'h0000, r);
    check(r, 16'hC23C);
    check({15'h0000, irqN}, 16'h0001);
    xfer(16'h0000, r);
    check(r, 16'h4200);
    parityEnable = 1'b0;
    $display("test receive done");
  endtask : t_rx

  task automatic t_framing;
    framingMask = 1'b1;
    send(9'h055, 8, 1'b0);
    check({15'h0000, irqN}, 16'h0000);
    xfer(16'h0000, r);
    check(r, 16'h4600);
    send(9'h00F, 8, 1'b1);
    xfer(16'h0000, r);
    check(r, 16'hC20F);
    check({15'h0000, irqN}, 16'h0001);
    framingMask = 1'b0;
    $display("test framing done");
  endtask : t_framing

  task automatic t_seven;
    sevenBitWords = 1'b1;
    parityEnable = 1'b1;
    send(9'h0AA, 8, 1'b1);
    xfer(16'h0000, r);
    check(r, 16'hC32A);
    fork
      xfer(16'h8083, r);
      grab(9, v);
    join
    check({7'h00, v}, 16'h0103);
    sevenBitWords = 1'b0;
    parityEnable = 1'b0;
    $display("test seven bit done");
  endtask : t_seven

  task automatic t_test;
    int t;
    int d;
    xfer(16'h4001, r);
    holdSelect = 1'b1;
    for (int c = 0; c < 16; c++) begin
      baudSelectField = 4'(c);
      d = (c >= 8 ? 3 : 1) << (c % 8);
      rts_rise(t);
      rts_rise(t);
      rts_rise(t);
      check(16'(t), 16'(4 * d));
      check({15'h0000, txd}, 16'h0000);
    end
    holdSelect = 1'b0;
    repeat (2) @(negedge sys_clk);
    baudSelectField = 4'h0;
    xfer(16'h4000, r);
    repeat (4) @(negedge sys_clk);
    check({15'h0000, txd}, 16'h0001);
    $display("test mode done");
  endtask : t_test

  task automatic final_report;
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    #(60000 * 5);
    nMismatch++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    rxd = 1'b1;
    ctsN = 1'b1;
    baudSelectField = 4'h0;
    {parityEnable, sevenBitWords, twoStopBits, dataAvailableMask, txEmptyMask, framingMask} = 6'h00;
    {start, holdSelect} = 2'h0;
    txWord = 16'h0000;
    nMismatch = 0;
    checksDone = 0;
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    t_idle();
    t_write();
    t_suppress();
    t_rx();
    t_framing();
    t_seven();
    t_test();
    final_report();
  end
endmodule : sud_uart_data_port_tb
`default_nettype wire
